// ===== design/csio_pkg.sv
// Package with register addresses, field positions and reset values for the core register file
package csio_pkg;
   // ----------------------------------------------------------------
   // Register addresses in the special function space
   // ----------------------------------------------------------------
   localparam logic [7:0] ADDR_PORT0_LATCH = 8'h80;
   localparam logic [7:0] ADDR_STACK_PTR = 8'h81;
   localparam logic [7:0] ADDR_DATA_POINTER16_LOW = 8'h82;
   localparam logic [7:0] ADDR_DATA_POINTER16_HIGH = 8'h83;
   localparam logic [7:0] ADDR_PORT1_LATCH = 8'h90;
   localparam logic [7:0] ADDR_PORT1_OE = 8'h91;
   localparam logic [7:0] ADDR_PORT2_LATCH = 8'hA0;
   localparam logic [7:0] ADDR_PORT2_OE = 8'hA1;
   localparam logic [7:0] ADDR_PORT0_OE = 8'hA2;
   localparam logic [7:0] ADDR_STATUS_WORD = 8'hD0;
   localparam logic [7:0] ADDR_MAIN_OPERAND = 8'hE0;
   localparam logic [7:0] ADDR_SECOND_OPERAND = 8'hF0;
   // ----------------------------------------------------------------
   // Status word field positions
   // ----------------------------------------------------------------
   localparam int PSW_CARRY_BIT = 7;
   localparam int PSW_HALF_CARRY_BIT = 6;
   localparam int PSW_USER_ZERO_BIT = 5;
   localparam int PSW_BANK_HIGH_BIT = 4;
   localparam int PSW_BANK_LOW_BIT = 3;
   localparam int PSW_EXCESS_BIT = 2;
   localparam int PSW_USER_ONE_BIT = 1;
   localparam int PSW_PARITY_BIT = 0;
   localparam logic [4:0] BANK_BASE_STEP = 5'h08;
   // ----------------------------------------------------------------
   // Widths and reset values
   // ----------------------------------------------------------------
   localparam int PORT0_PINS = 4;
   localparam int PORT1_PINS = 6;
   localparam int PORT2_PINS = 2;
   localparam logic [7:0] RESET_STACK_PTR = 8'h07;
   localparam logic [15:0] RESET_PROG_CNT = 16'h0000;
   localparam logic [7:0] RESET_ZERO_BYTE = 8'h00;
   localparam logic [7:0] RESET_PORT0_LATCH = 8'hFF;
   localparam logic [7:0] RESET_PORT1_LATCH = 8'hFF;
   localparam logic [7:0] RESET_PORT2_LATCH = 8'h00;
   localparam logic [7:0] RESET_PORT_OE = 8'h00;
endpackage

// ===== design/csio_port_if.sv
// Interface carrying one port's latch, drive enable and sampled pin levels
`timescale 1ns/1ps
`default_nettype none
interface csio_port_if;
   logic [7:0] latch_val;
   logic [7:0] out_enable;
   logic [7:0] pin_level;
   // Register side owns latch and enable, the pin cell returns the level
   modport reg_side (output latch_val, output out_enable, input pin_level);
   modport pin_side (input latch_val, input out_enable, output pin_level);
endinterface
`default_nettype wire

// ===== design/csio_pin_cell.sv
// One port's pin cells: output drivers plus synchronised input buffers
`timescale 1ns/1ps
`default_nettype none
module csio_pin_cell #(
   parameter int PINS = 4
) (
   // Clock and reset
   input wire logic clk_in,
   input wire logic reset_n_in,
   // Register side
   csio_port_if.pin_side port,
   // Pin side
   input wire logic [PINS-1:0] pin_in,
   output logic [PINS-1:0] pin_out,
   output logic [PINS-1:0] pin_oe_out
);
   logic [PINS-1:0] sync_first_reg;
   logic [PINS-1:0] sync_second_reg;

   // ----------------------------------------------------------------
   // Output drivers
   // ----------------------------------------------------------------
   // Latch value drives level, enable only when direction bit set
   assign pin_out = port.latch_val[PINS-1:0];
   assign pin_oe_out = port.out_enable[PINS-1:0];

   // ----------------------------------------------------------------
   // Input buffers
   // ----------------------------------------------------------------
   // Two stages since the pad is asynchronous to the core clock
   always_ff @(posedge clk_in or negedge reset_n_in) begin
      if (!reset_n_in) begin
         sync_first_reg <= '0;
         sync_second_reg <= '0;
      end else begin
         sync_first_reg <= pin_in;
         sync_second_reg <= sync_first_reg;
      end
   end

   // Unused upper bits read as zero
   assign port.pin_level = {{(8-PINS){1'b0}}, sync_second_reg};
endmodule
`default_nettype wire

// ===== design/csio_core_regs.sv
// Core architectural registers and the three digital port registers
//
// Functional notes
// - Accumulator is main operand source and destination
// - Second operand register for multiply, divide, scratch
// - Status word carry, half carry, excess, parity
// - Status bit 5 is software-written user flag
// - Bank select bits choose working register bank
// - Stack pointer resets to 0x07
// - Stack pointer increments before push or call
// - Sixteen-bit data pointer from two byte halves
// - Data pointer addresses table reads and external data
// - Program counter sixteen bits, reset to zero
// - Program counter advances on fetch and operand
// - Port latch bit drives matching pin level
// - Direction bit one makes pin an output
// - Port latches at 0x80, 0x90, 0xA0
// - Direction registers at 0xA2, 0x91, 0xA1
// - Ports serve pins 4-7, 8-11/14-15, 16-17
// - Every port pin is bidirectional
// - Port read returns real pin level
`timescale 1ns/1ps
`default_nettype none
module csio_core_regs (
   // Clock and reset
   input wire logic clk_in,
   input wire logic reset_n_in,
   // Special function register bus from the core
   input wire logic [7:0] sfr_addr_in,
   input wire logic sfr_wr_in,
   input wire logic sfr_rd_in,
   input wire logic [7:0] sfr_wdata_in,
   output logic [7:0] sfr_rdata_out,
   output logic sfr_hit_out,
   // Execution-unit writes of the working registers
   input wire logic acc_load_in,
   input wire logic [7:0] acc_value_in,
   input wire logic b_load_in,
   input wire logic [7:0] b_value_in,
   input wire logic flags_load_in,
   input wire logic carry_in,
   input wire logic half_carry_in,
   input wire logic excess_in,
   // Stack, program counter and data pointer controls
   input wire logic stack_push_in,
   input wire logic stack_pop_in,
   input wire logic pc_fetch_in,
   input wire logic pc_load_in,
   input wire logic [15:0] pc_value_in,
   input wire logic data_pointer16_load_in,
   input wire logic [15:0] data_pointer16_value_in,
   input wire logic data_pointer16_inc_in,
   // Architectural state towards the execution unit
   output logic [7:0] main_operand_out,
   output logic [7:0] second_operand_out,
   output logic [7:0] status_word_out,
   output logic [4:0] bank_base_out,
   output logic [7:0] stack_pointer_out,
   output logic [7:0] stack_addr_out,
   output logic [15:0] data_pointer16_out,
   output logic [15:0] table_addr_out,
   output logic [15:0] prog_counter_out,
   // Digital I/O pins
   input wire logic [3:0] port0_pin_in,
   output logic [3:0] port0_pin_out,
   output logic [3:0] port0_pin_oe_out,
   input wire logic [5:0] port1_pin_in,
   output logic [5:0] port1_pin_out,
   output logic [5:0] port1_pin_oe_out,
   input wire logic [1:0] port2_pin_in,
   output logic [1:0] port2_pin_out,
   output logic [1:0] port2_pin_oe_out
);
   // ----------------------------------------------------------------
   // Storage
   // ----------------------------------------------------------------
   logic [7:0] main_operand_reg;
   logic [7:0] second_operand_reg;
   logic carry_flag_reg;
   logic bcd_half_carry_flag_reg;
   logic user_flag_zero_reg;
   logic bank_select_high_reg;
   logic bank_select_low_reg;
   logic signed_excess_flag_reg;
   logic user_flag_one_reg;
   logic parity_flag;
   logic [7:0] stack_pointer_reg;
   logic [7:0] data_pointer_low_reg;
   logic [7:0] data_pointer_high_reg;
   logic [15:0] prog_counter_reg;
   logic [7:0] port_zero_latch_reg;
   logic [7:0] port_one_latch_reg;
   logic [7:0] port_two_latch_reg;
   logic [7:0] port_zero_out_enable_reg;
   logic [7:0] port_one_out_enable_reg;
   logic [7:0] port_two_out_enable_reg;
   logic [7:0] read_mux;
   logic read_hit;
   logic [15:0] data_pointer16_sum;

   csio_port_if port0_if ();
   csio_port_if port1_if ();
   csio_port_if port2_if ();

   // Bus write strobe per address
   function automatic logic wr_at(input logic [7:0] addr);
      wr_at = sfr_wr_in && (sfr_addr_in == addr);
   endfunction

   // ----------------------------------------------------------------
   // Operand registers
   // ----------------------------------------------------------------
   // Bus write takes priority over the execution unit on a clash
   always_ff @(posedge clk_in or negedge reset_n_in) begin
      if (!reset_n_in) begin
         main_operand_reg <= csio_pkg::RESET_ZERO_BYTE;
      end else if (wr_at(csio_pkg::ADDR_MAIN_OPERAND)) begin
         main_operand_reg <= sfr_wdata_in;
      end else if (acc_load_in) begin
         main_operand_reg <= acc_value_in;
      end
   end

   // Scratch storage as well as the multiply and divide partner
   always_ff @(posedge clk_in or negedge reset_n_in) begin
      if (!reset_n_in) begin
         second_operand_reg <= csio_pkg::RESET_ZERO_BYTE;
      end else if (wr_at(csio_pkg::ADDR_SECOND_OPERAND)) begin
         second_operand_reg <= sfr_wdata_in;
      end else if (b_load_in) begin
         second_operand_reg <= b_value_in;
      end
   end

   // ----------------------------------------------------------------
   // Status word
   // ----------------------------------------------------------------
   // Arithmetic flags follow the execution unit unless software writes
   always_ff @(posedge clk_in or negedge reset_n_in) begin
      if (!reset_n_in) begin
         carry_flag_reg <= 1'b0;
         bcd_half_carry_flag_reg <= 1'b0;
         signed_excess_flag_reg <= 1'b0;
      end else if (wr_at(csio_pkg::ADDR_STATUS_WORD)) begin
         carry_flag_reg <= sfr_wdata_in[csio_pkg::PSW_CARRY_BIT];
         bcd_half_carry_flag_reg <= sfr_wdata_in[csio_pkg::PSW_HALF_CARRY_BIT];
         signed_excess_flag_reg <= sfr_wdata_in[csio_pkg::PSW_EXCESS_BIT];
      end else if (flags_load_in) begin
         carry_flag_reg <= carry_in;
         bcd_half_carry_flag_reg <= half_carry_in;
         signed_excess_flag_reg <= excess_in;
      end
   end

   // Software-only bits: user flags and bank selection
   always_ff @(posedge clk_in or negedge reset_n_in) begin
      if (!reset_n_in) begin
         user_flag_zero_reg <= 1'b0;
         bank_select_high_reg <= 1'b0;
         bank_select_low_reg <= 1'b0;
         user_flag_one_reg <= 1'b0;
      end else if (wr_at(csio_pkg::ADDR_STATUS_WORD)) begin
         user_flag_zero_reg <= sfr_wdata_in[csio_pkg::PSW_USER_ZERO_BIT];
         bank_select_high_reg <= sfr_wdata_in[csio_pkg::PSW_BANK_HIGH_BIT];
         bank_select_low_reg <= sfr_wdata_in[csio_pkg::PSW_BANK_LOW_BIT];
         user_flag_one_reg <= sfr_wdata_in[csio_pkg::PSW_USER_ONE_BIT];
      end
   end

   // Parity is live from the accumulator, so writes to it are ignored
   assign parity_flag = ^main_operand_reg;

   always_comb begin
      status_word_out = '0;
      status_word_out[csio_pkg::PSW_CARRY_BIT] = carry_flag_reg;
      status_word_out[csio_pkg::PSW_HALF_CARRY_BIT] = bcd_half_carry_flag_reg;
      status_word_out[csio_pkg::PSW_USER_ZERO_BIT] = user_flag_zero_reg;
      status_word_out[csio_pkg::PSW_BANK_HIGH_BIT] = bank_select_high_reg;
      status_word_out[csio_pkg::PSW_BANK_LOW_BIT] = bank_select_low_reg;
      status_word_out[csio_pkg::PSW_EXCESS_BIT] = signed_excess_flag_reg;
      status_word_out[csio_pkg::PSW_USER_ONE_BIT] = user_flag_one_reg;
      status_word_out[csio_pkg::PSW_PARITY_BIT] = parity_flag;
   end

   // Bank base is 8 times the bank number: 0x00, 0x08, 0x10, 0x18
   assign bank_base_out = 5'({bank_select_high_reg, bank_select_low_reg})
      * csio_pkg::BANK_BASE_STEP;

   // ----------------------------------------------------------------
   // Stack pointer
   // ----------------------------------------------------------------
   // Pre-increment on push, post-decrement on pop
   always_ff @(posedge clk_in or negedge reset_n_in) begin
      if (!reset_n_in) begin
         stack_pointer_reg <= csio_pkg::RESET_STACK_PTR;
      end else if (wr_at(csio_pkg::ADDR_STACK_PTR)) begin
         stack_pointer_reg <= sfr_wdata_in;
      end else if (stack_push_in) begin
         stack_pointer_reg <= stack_pointer_reg + 8'h01;
      end else if (stack_pop_in) begin
         stack_pointer_reg <= stack_pointer_reg - 8'h01;
      end
   end

   // Store address during a push is the already-incremented pointer
   assign stack_addr_out = stack_push_in ? stack_pointer_reg + 8'h01
      : stack_pointer_reg;

   // ----------------------------------------------------------------
   // Data pointer
   // ----------------------------------------------------------------
   assign data_pointer16_sum = {data_pointer_high_reg, data_pointer_low_reg} + 16'h0001;

   // Each half loads alone by byte moves; whole loads come from the core
   always_ff @(posedge clk_in or negedge reset_n_in) begin
      if (!reset_n_in) begin
         data_pointer_low_reg <= csio_pkg::RESET_ZERO_BYTE;
      end else if (wr_at(csio_pkg::ADDR_DATA_POINTER16_LOW)) begin
         data_pointer_low_reg <= sfr_wdata_in;
      end else if (data_pointer16_load_in) begin
         data_pointer_low_reg <= data_pointer16_value_in[7:0];
      end else if (data_pointer16_inc_in) begin
         data_pointer_low_reg <= data_pointer16_sum[7:0];
      end
   end

   always_ff @(posedge clk_in or negedge reset_n_in) begin
      if (!reset_n_in) begin
         data_pointer_high_reg <= csio_pkg::RESET_ZERO_BYTE;
      end else if (wr_at(csio_pkg::ADDR_DATA_POINTER16_HIGH)) begin
         data_pointer_high_reg <= sfr_wdata_in;
      end else if (data_pointer16_load_in) begin
         data_pointer_high_reg <= data_pointer16_value_in[15:8];
      end else if (data_pointer16_inc_in) begin
         data_pointer_high_reg <= data_pointer16_sum[15:8];
      end
   end

   assign data_pointer16_out = {data_pointer_high_reg, data_pointer_low_reg};
   // Code table address is pointer plus accumulator
   assign table_addr_out = data_pointer16_out + {8'h00, main_operand_reg};

   // ----------------------------------------------------------------
   // Program counter
   // ----------------------------------------------------------------
   // Jumps take priority over the fetch increment
   always_ff @(posedge clk_in or negedge reset_n_in) begin
      if (!reset_n_in) begin
         prog_counter_reg <= csio_pkg::RESET_PROG_CNT;
      end else if (pc_load_in) begin
         prog_counter_reg <= pc_value_in;
      end else if (pc_fetch_in) begin
         prog_counter_reg <= prog_counter_reg + 16'h0001;
      end
   end

   // ----------------------------------------------------------------
   // Port latches and direction registers
   // ----------------------------------------------------------------
   // Latches accept writes whatever the direction setting
   always_ff @(posedge clk_in or negedge reset_n_in) begin
      if (!reset_n_in) begin
         port_zero_latch_reg <= csio_pkg::RESET_PORT0_LATCH;
         port_one_latch_reg <= csio_pkg::RESET_PORT1_LATCH;
         port_two_latch_reg <= csio_pkg::RESET_PORT2_LATCH;
      end else begin
         if (wr_at(csio_pkg::ADDR_PORT0_LATCH)) begin
            port_zero_latch_reg <= sfr_wdata_in;
         end
         if (wr_at(csio_pkg::ADDR_PORT1_LATCH)) begin
            port_one_latch_reg <= sfr_wdata_in;
         end
         if (wr_at(csio_pkg::ADDR_PORT2_LATCH)) begin
            port_two_latch_reg <= sfr_wdata_in;
         end
      end
   end

   // All pins come up as inputs so nothing fights the board at reset
   always_ff @(posedge clk_in or negedge reset_n_in) begin
      if (!reset_n_in) begin
         port_zero_out_enable_reg <= csio_pkg::RESET_PORT_OE;
         port_one_out_enable_reg <= csio_pkg::RESET_PORT_OE;
         port_two_out_enable_reg <= csio_pkg::RESET_PORT_OE;
      end else begin
         if (wr_at(csio_pkg::ADDR_PORT0_OE)) begin
            port_zero_out_enable_reg <= sfr_wdata_in;
         end
         if (wr_at(csio_pkg::ADDR_PORT1_OE)) begin
            port_one_out_enable_reg <= sfr_wdata_in;
         end
         if (wr_at(csio_pkg::ADDR_PORT2_OE)) begin
            port_two_out_enable_reg <= sfr_wdata_in;
         end
      end
   end

   assign port0_if.latch_val = port_zero_latch_reg;
   assign port0_if.out_enable = port_zero_out_enable_reg;
   assign port1_if.latch_val = port_one_latch_reg;
   assign port1_if.out_enable = port_one_out_enable_reg;
   assign port2_if.latch_val = port_two_latch_reg;
   assign port2_if.out_enable = port_two_out_enable_reg;

   // ----------------------------------------------------------------
   // Pin cells, one per port, sized to the pins each serves
   // ----------------------------------------------------------------
   csio_pin_cell #(.PINS(csio_pkg::PORT0_PINS)) u_port0 (
      .clk_in(clk_in),
      .reset_n_in(reset_n_in),
      .port(port0_if.pin_side),
      .pin_in(port0_pin_in),
      .pin_out(port0_pin_out),
      .pin_oe_out(port0_pin_oe_out)
   );

   csio_pin_cell #(.PINS(csio_pkg::PORT1_PINS)) u_port1 (
      .clk_in(clk_in),
      .reset_n_in(reset_n_in),
      .port(port1_if.pin_side),
      .pin_in(port1_pin_in),
      .pin_out(port1_pin_out),
      .pin_oe_out(port1_pin_oe_out)
   );

   csio_pin_cell #(.PINS(csio_pkg::PORT2_PINS)) u_port2 (
      .clk_in(clk_in),
      .reset_n_in(reset_n_in),
      .port(port2_if.pin_side),
      .pin_in(port2_pin_in),
      .pin_out(port2_pin_out),
      .pin_oe_out(port2_pin_oe_out)
   );

   // ----------------------------------------------------------------
   // Read path
   // ----------------------------------------------------------------
   // Port reads show the pad, not the latch, even for outputs
   always_comb begin
      read_mux = 8'h00;
      read_hit = 1'b1;
      case (sfr_addr_in)
         csio_pkg::ADDR_PORT0_LATCH: read_mux = port0_if.pin_level;
         csio_pkg::ADDR_PORT1_LATCH: read_mux = port1_if.pin_level;
         csio_pkg::ADDR_PORT2_LATCH: read_mux = port2_if.pin_level;
         csio_pkg::ADDR_PORT0_OE: read_mux = port_zero_out_enable_reg;
         csio_pkg::ADDR_PORT1_OE: read_mux = port_one_out_enable_reg;
         csio_pkg::ADDR_PORT2_OE: read_mux = port_two_out_enable_reg;
         csio_pkg::ADDR_STACK_PTR: read_mux = stack_pointer_reg;
         csio_pkg::ADDR_DATA_POINTER16_LOW: read_mux = data_pointer_low_reg;
         csio_pkg::ADDR_DATA_POINTER16_HIGH: read_mux = data_pointer_high_reg;
         csio_pkg::ADDR_STATUS_WORD: read_mux = status_word_out;
         csio_pkg::ADDR_MAIN_OPERAND: read_mux = main_operand_reg;
         csio_pkg::ADDR_SECOND_OPERAND: read_mux = second_operand_reg;
         default: read_hit = 1'b0;
      endcase
   end

   // Registered read data, one cycle after the strobe; misses read zero
   always_ff @(posedge clk_in or negedge reset_n_in) begin
      if (!reset_n_in) begin
         sfr_rdata_out <= 8'h00;
      end else if (sfr_rd_in) begin
         sfr_rdata_out <= read_mux;
      end
   end

   assign sfr_hit_out = read_hit;
   assign main_operand_out = main_operand_reg;
   assign second_operand_out = second_operand_reg;
   assign stack_pointer_out = stack_pointer_reg;
   assign prog_counter_out = prog_counter_reg;
endmodule
`default_nettype wire

// ===== tb/csio_pad_model.sv
// Pad model for one port: driven bits follow the port, released bits show outside
`timescale 1ns/1ps
`default_nettype none
module csio_pad_model #(
   parameter int W = 4
) (
   // Port side and outside level
   input wire logic [W-1:0] drv_in,
   input wire logic [W-1:0] en_in,
   input wire logic [W-1:0] ext_in,
   output logic [W-1:0] level_out
);
   // A released pin must show the outside, never the last driven value
   assign level_out = (drv_in & en_in) | (ext_in & ~en_in);
endmodule
`default_nettype wire

// ===== tb/csio_core_regs_asserts.sv
// Concurrent assertions on the core register file ports
`timescale 1ns/1ps
`default_nettype none
module csio_core_regs_chk (
   // Clock, reset and watched ports, grouped to keep the file short
   input wire logic clk_in, reset_n_in, sfr_wr_in, stack_push_in, pc_fetch_in, pc_load_in,
   input wire logic [7:0] sfr_addr_in, sfr_wdata_in, main_operand_out, status_word_out,
   input wire logic [7:0] stack_pointer_out, stack_addr_out,
   input wire logic [4:0] bank_base_out,
   input wire logic [15:0] data_pointer16_out, table_addr_out, prog_counter_out,
   input wire logic [3:0] port0_pin_out, port0_pin_oe_out
);
   // ----------------------------------------------------------------
   // Properties
   // ----------------------------------------------------------------
   default clocking @(posedge clk_in); endclocking
   default disable iff (!reset_n_in);
   sp_reset_a: assert property ($rose(reset_n_in) |-> stack_pointer_out == 8'h07)
      else $error("stack pointer not 07 after reset");
   pc_step_a: assert property (pc_fetch_in && !pc_load_in |=>
      prog_counter_out == $past(prog_counter_out) + 16'h0001) else $error("pc step");
   sp_push_a: assert property (stack_push_in && !(sfr_wr_in && sfr_addr_in == 8'h81) |=>
      stack_pointer_out == $past(stack_pointer_out) + 8'h01) else $error("push step");
   push_addr_a: assert property (stack_push_in |-> stack_addr_out == stack_pointer_out + 8'h01)
      else $error("push address");
   parity_flag_a: assert property (status_word_out[0] == ^main_operand_out)
      else $error("parity flag");
   bank_base_a: assert property (bank_base_out == {status_word_out[4:3], 3'h0})
      else $error("bank base");
   table_addr_a: assert property (table_addr_out == data_pointer16_out + {8'h00, main_operand_out})
      else $error("table address");
   dpl_write_a: assert property (sfr_wr_in && sfr_addr_in == 8'h82 |=>
      data_pointer16_out[7:0] == $past(sfr_wdata_in)) else $error("pointer low write");
   oe_write_a: assert property (sfr_wr_in && sfr_addr_in == 8'hA2 |=>
      port0_pin_oe_out == $past(sfr_wdata_in[3:0])) else $error("enable write");
   latch_write_a: assert property (sfr_wr_in && sfr_addr_in == 8'h80 |=>
      port0_pin_out == $past(sfr_wdata_in[3:0])) else $error("latch write");
endmodule
bind csio_core_regs csio_core_regs_chk u_csio_core_regs_chk (.*);
`default_nettype wire

// ===== tb/test_csio_core_regs.sv
// Self-checking testbench for the core register file and its ports
`timescale 1ns/1ps
`default_nettype none
module test_csio_core_regs;
   logic clk_in, reset_n_in, sfr_wr_in, sfr_rd_in, acc_load_in, b_load_in, flags_load_in;
   logic carry_in, half_carry_in, excess_in, stack_push_in, stack_pop_in, pc_fetch_in;
   logic pc_load_in, data_pointer16_load_in, data_pointer16_inc_in, sfr_hit_out;
   logic [7:0] sfr_addr_in, sfr_wdata_in, sfr_rdata_out, acc_value_in, b_value_in;
   logic [7:0] main_operand_out, second_operand_out, status_word_out, stack_pointer_out;
   logic [7:0] stack_addr_out;
   logic [4:0] bank_base_out;
   logic [15:0] pc_value_in, data_pointer16_value_in, data_pointer16_out, table_addr_out, prog_counter_out;
   logic [3:0] port0_pin_in, port0_pin_out, port0_pin_oe_out, ext0;
   logic [5:0] port1_pin_in, port1_pin_out, port1_pin_oe_out, ext1;
   logic [1:0] port2_pin_in, port2_pin_out, port2_pin_oe_out, ext2;
   logic [7:0] ra [0:8] = '{8'h81, 8'h82, 8'h83, 8'h91, 8'hA1, 8'hA2, 8'hD0, 8'hE0, 8'hF0};
   logic [7:0] la [0:2] = '{8'h80, 8'h90, 8'hA0};
   logic [7:0] oa [0:2] = '{8'hA2, 8'h91, 8'hA1};
   logic [7:0] ev [0:2] = '{8'h05, 8'h15, 8'h01};
   logic [7:0] dv [0:2] = '{8'h0A, 8'h1A, 8'h02};
   int error_cnt = 0;
   int checks = 0;
   csio_core_regs u_csio_core_regs (.*);
   csio_pad_model #(.W(4)) u_csio_pad_model_0 (.drv_in(port0_pin_out),
      .en_in(port0_pin_oe_out), .ext_in(ext0), .level_out(port0_pin_in));
   csio_pad_model #(.W(6)) u_csio_pad_model_1 (.drv_in(port1_pin_out),
      .en_in(port1_pin_oe_out), .ext_in(ext1), .level_out(port1_pin_in));
   csio_pad_model #(.W(2)) u_csio_pad_model_2 (.drv_in(port2_pin_out),
      .en_in(port2_pin_oe_out), .ext_in(ext2), .level_out(port2_pin_in));
   // ----------------------------------------------------------------
   // Clock, hang guard and access tasks
   // ----------------------------------------------------------------
   initial begin
      clk_in = 1'b0;
      forever #5 clk_in = ~clk_in;
   end
   // Hang guard, far beyond a clean run
   initial begin
      #500000;
      error_cnt++;
      summarize();
   end
   task automatic chk(input string n, input logic [15:0] e, input logic [15:0] g);
      checks++;
      if (g !== e) begin
         error_cnt++;
         $display("wrong value %s expected %h seen %h", n, e, g);
      end
   endtask
   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      {sfr_addr_in, sfr_wdata_in, sfr_wr_in} = {a, d, 1'b1};
      @(negedge clk_in);
      sfr_wr_in = 1'b0;
   endtask
   // Read data lands one edge after the strobe edge
   task automatic rd(input logic [7:0] a, input logic [7:0] e);
      {sfr_addr_in, sfr_rd_in} = {a, 1'b1};
      @(negedge clk_in);
      sfr_rd_in = 1'b0;
      chk("read data", {8'h00, e}, {8'h00, sfr_rdata_out});
   endtask
   task automatic summarize();
      $display("checks %0d mismatches %0d", checks, error_cnt);
      if (error_cnt == 0 && checks > 0) begin
         $display("Run complete: PASS");
      end else begin
         $display("Run complete: FAIL");
      end
      $finish;
   endtask
   // Reset, exec, registers, ports
   initial begin
      {sfr_wr_in, sfr_rd_in, acc_load_in, b_load_in, flags_load_in, carry_in} = '0;
      {half_carry_in, excess_in, stack_push_in, stack_pop_in, pc_fetch_in, pc_load_in} = '0;
      {data_pointer16_load_in, data_pointer16_inc_in, sfr_addr_in, sfr_wdata_in, acc_value_in, b_value_in} = '0;
      {pc_value_in, data_pointer16_value_in, ext0, ext1, ext2} = {32'h0, 4'h5, 6'h15, 2'h1};
      reset_n_in = 1'b0;
      repeat (16) @(negedge clk_in);
      reset_n_in = 1'b1;
      @(negedge clk_in);
      chk("pin outs", 16'hFFC0, {port0_pin_out, port1_pin_out, port2_pin_out, 4'h0});
      chk("pin enables", 16'h0000, {port0_pin_oe_out, port1_pin_oe_out, port2_pin_oe_out, 4'h0});
      chk("pc reset", 16'h0000, prog_counter_out);
      for (int i = 0; i < 9; i++) rd(ra[i], (i == 0) ? 8'h07 : 8'h00);
      $display("test reset done");
      {acc_load_in, b_load_in, flags_load_in, carry_in, half_carry_in, excess_in} = '1;
      {stack_push_in, data_pointer16_load_in, pc_fetch_in} = '1;
      {acc_value_in, b_value_in, data_pointer16_value_in} = {8'h07, 8'h5A, 16'h1234};
      #1 chk("push address", 16'h0008, 16'(stack_addr_out));
      @(negedge clk_in);
      {acc_load_in, b_load_in, flags_load_in, stack_push_in, data_pointer16_load_in, pc_fetch_in} = '0;
      chk("operands", 16'h075A, {main_operand_out, second_operand_out});
      chk("status", 16'h00C5, 16'(status_word_out));
      chk("stack ptr", 16'h0008, 16'(stack_pointer_out));
      chk("pointer", 16'h1234, data_pointer16_out);
      chk("table addr", 16'h123B, table_addr_out);
      chk("pc", 16'h0001, prog_counter_out);
      {stack_pop_in, data_pointer16_inc_in, pc_load_in, pc_fetch_in, pc_value_in} = {4'hF, 16'h00FF};
      @(negedge clk_in);
      {stack_pop_in, data_pointer16_inc_in, pc_load_in, pc_fetch_in} = '0;
      chk("sp pointer pc", 16'h07FF, {stack_pointer_out, prog_counter_out[7:0]});
      chk("pointer inc", 16'h1235, data_pointer16_out);
      $display("test exec done");
      for (int i = 0; i < 5; i++) wr(ra[(i < 3) ? i : i + 4], 8'hA5);
      for (int i = 0; i < 5; i++) rd(ra[(i < 3) ? i : i + 4], 8'hA5);
      wr(8'hD0, 8'hFF);
      rd(8'hD0, 8'hFE);
      chk("mapped hit", 16'h0001, 16'(sfr_hit_out));
      for (int b = 0; b < 4; b++) begin
         wr(8'hD0, 8'(b << 3));
         chk("bank base", 16'(b * 8), 16'(bank_base_out));
      end
      wr(8'h84, 8'h55);
      rd(8'h84, 8'h00);
      #1 chk("unmapped hit", 16'h0000, 16'(sfr_hit_out));
      $display("test registers done");
      for (int i = 0; i < 3; i++) begin
         wr(la[i], 8'h5A);
         repeat (3) @(negedge clk_in);
         rd(la[i], ev[i]);
         wr(oa[i], 8'hFF);
         repeat (3) @(negedge clk_in);
         rd(la[i], dv[i]);
      end
      chk("pin outs", 16'hA6A0, {port0_pin_out, port1_pin_out, port2_pin_out, 4'h0});
      chk("pin enables", 16'hFFF0, {port0_pin_oe_out, port1_pin_oe_out, port2_pin_oe_out, 4'h0});
      $display("test ports done");
      summarize();
   end
endmodule
`default_nettype wire
